// *** design/system_configuration_control.sv ***
module system_configuration_control (
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        clk_en_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        system_unlocked_i,
   input  wire logic        cpu_in_isr_i,
   input  wire logic        sleep_active_i,
   input  wire logic        usb_phy_clk_i,
   input  wire logic        pin_select_wr_req_i,
   input  wire logic        module_disable_wr_req_i,
   input  wire logic        permission_group_wr_req_i,
   output logic             dma_sram_high_priority_o,
   output logic             cpu_sram_high_priority_o,
   output logic             capture_alt_timebase_select_o,
   output logic             compare_alt_timebase_select_o,
   output logic             pin_select_wr_allow_o,
   output logic             module_disable_wr_allow_o,
   output logic             permission_group_wr_allow_o,
   output logic             usb_phy_clk_gated_o,
   output logic             usb_phy_clk_stopped_o,
   output logic [1:0]       memory_error_correction_control_o,
   output logic             boundary_scan_port_enable_o,
   output logic             trace_output_enable_o,
   output logic             test_data_out_enable_o,
   output logic             analog_io_charge_pump_enable_o
);
   import syscfg_pkg::*;

   logic [31:0] ctrl_q;
   logic [31:0] ctrl_d;
   logic        dropped_q;
   logic        dropped_d;
   logic [31:0] rdata_q;
   logic [2:0]  unlock_sync_q;
   logic        unlock_q;

   // Bus decode: every transfer completes in its first access cycle.
   wire         access    = psel_i & penable_i & clk_en_i;
   wire         hit_ctrl  = (paddr_i == SYSCFG_CTRL_OFFSET);
   wire         hit_stat  = (paddr_i == SYSCFG_STAT_OFFSET);
   wire         hit_any   = hit_ctrl | hit_stat;
   wire         wr_ctrl   = access & pwrite_i & hit_ctrl;
   wire         rd_setup  = psel_i & ~penable_i & ~pwrite_i;

   // Byte-lane mask built from the write strobes.
   wire  [31:0] lane_mask = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};

   // Protected bits move only when unlocked; others follow the lanes.
   wire  [31:0] wr_mask   = lane_mask & SYSCFG_IMPL_MASK
                            & (unlock_q ? 32'hffff_ffff : ~SYSCFG_LOCKED_MASK);
   wire         locked_hit = wr_ctrl & ~unlock_q & |(lane_mask & SYSCFG_LOCKED_MASK & (pwdata_i ^ ctrl_q));

   // Next value of the control word and the dropped-write flag.
   always_comb begin
      ctrl_d    = ctrl_q;
      dropped_d = dropped_q;
      if (wr_ctrl) begin
         ctrl_d = (ctrl_q & ~wr_mask) | (pwdata_i & wr_mask);
      end
      if (access & pwrite_i & hit_stat & pwdata_i[STAT_DROPPED_BIT]) begin
         dropped_d = 1'b0;
      end
      if (locked_hit) begin
         dropped_d = 1'b1;
      end
   end

   // Unlock level from the key logic; the first stage feeds only the second.
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         unlock_sync_q <= 3'h0;
         unlock_q      <= 1'b0;
      end else if (clk_en_i) begin
         unlock_sync_q <= {unlock_sync_q[1:0], system_unlocked_i};
         if (unlock_sync_q[2] == unlock_sync_q[1]) begin
            unlock_q <= unlock_sync_q[2];
         end
      end
   end

   // Control register state.
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         ctrl_q    <= SYSCFG_CTRL_RESET;
         dropped_q <= 1'b0;
      end else if (clk_en_i) begin
         ctrl_q    <= ctrl_d;
         dropped_q <= dropped_d;
      end
   end

   // Read data is captured in the setup cycle so it leaves a flip-flop.
   wire  [31:0] stat_word = {30'h0, dropped_q, unlock_q};
   wire  [31:0] rd_mux    = hit_ctrl ? (ctrl_q & SYSCFG_IMPL_MASK) : (hit_stat ? stat_word : 32'h0);

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         rdata_q <= 32'h0;
      end else if (clk_en_i && rd_setup) begin
         rdata_q <= rd_mux;
      end
   end

   assign prdata_o  = rdata_q;
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~hit_any;

   // Arbitration and timebase steering from the register bits; CPU priority is also gated by cpu_in_isr_i.
   assign dma_sram_high_priority_o      = ctrl_q[DMA_PRI_BIT];
   assign cpu_sram_high_priority_o      = ctrl_q[CPU_PRI_BIT] & cpu_in_isr_i;
   assign capture_alt_timebase_select_o = ctrl_q[CAP_ALT_BIT];
   assign compare_alt_timebase_select_o = ctrl_q[CMP_ALT_BIT];

   // Write permission for the guarded register groups.
   assign pin_select_wr_allow_o       = pin_select_wr_req_i & ~ctrl_q[PIN_LOCK_BIT];
   assign module_disable_wr_allow_o   = module_disable_wr_req_i & ~ctrl_q[PMD_LOCK_BIT];
   assign permission_group_wr_allow_o = permission_group_wr_req_i & ~ctrl_q[PG_LOCK_BIT];

   // PHY clock gate; the clock is passed through a plain AND, so the clock tree owner must glitch-proof it.
   assign usb_phy_clk_stopped_o = ctrl_q[USB_STOP_BIT] & sleep_active_i;
   assign usb_phy_clk_gated_o   = usb_phy_clk_i & ~usb_phy_clk_stopped_o;

   // Pass-through configuration fields.
   assign memory_error_correction_control_o = ctrl_q[ECC_LO_BIT+1:ECC_LO_BIT];
   assign boundary_scan_port_enable_o       = ctrl_q[JTAG_BIT];
   assign trace_output_enable_o             = ctrl_q[TRACE_BIT];
   assign test_data_out_enable_o            = ctrl_q[TDO_BIT];
   assign analog_io_charge_pump_enable_o    = ctrl_q[ANA_PUMP_BIT];

   // Assertions; each one watches what this block drives.

   // The word leaves reset at its documented value.
   AST_RESET_VALUE: assert property (@(posedge clk_i)
      $rose(reset_n_i) |-> ctrl_q == SYSCFG_CTRL_RESET)
      else $error("control word not at reset value");

   // A locked write must not move a protected bit.
   AST_LOCKED_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (wr_ctrl && !unlock_q) |=> ((ctrl_q & SYSCFG_LOCKED_MASK) == ($past(ctrl_q) & SYSCFG_LOCKED_MASK)))
      else $error("protected bits moved while locked");

   // Holes in the word never hold a one.
   AST_UNIMPL_ZERO: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (ctrl_q & ~SYSCFG_IMPL_MASK) == 32'h0)
      else $error("unimplemented bits set");

   // A refused change of a protected bit raises the flag.
   AST_DROP_FLAG: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      locked_hit |=> dropped_q)
      else $error("dropped write not flagged");

   // An unlocked write to the top lane sets the DMA priority.
   AST_DMA_PRI: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (wr_ctrl && unlock_q && pstrb_i[3]) |=> dma_sram_high_priority_o == $past(pwdata_i[DMA_PRI_BIT]))
      else $error("dma priority not updated");

   // CPU priority only while an interrupt is serviced.
   AST_CPU_PRI: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      cpu_sram_high_priority_o |-> (cpu_in_isr_i && ctrl_q[CPU_PRI_BIT]))
      else $error("cpu priority outside interrupt service");

   // Capture timebase follows an unlocked write.
   AST_CAP_SEL: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (wr_ctrl && unlock_q && pstrb_i[2]) |=> capture_alt_timebase_select_o == $past(pwdata_i[CAP_ALT_BIT]))
      else $error("capture timebase not updated");

   // Compare timebase follows an unlocked write.
   AST_CMP_SEL: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (wr_ctrl && unlock_q && pstrb_i[2]) |=> compare_alt_timebase_select_o == $past(pwdata_i[CMP_ALT_BIT]))
      else $error("compare timebase not updated");

   // A set pin-select lock refuses every attempt.
   AST_PIN_LOCK: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      ctrl_q[PIN_LOCK_BIT] |-> !pin_select_wr_allow_o)
      else $error("pin select write passed lock");

   // Module-disable attempts pass exactly when the module-disable lock is clear.
   AST_PMD_LOCK: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      module_disable_wr_req_i |-> (module_disable_wr_allow_o != ctrl_q[PMD_LOCK_BIT]))
      else $error("module disable gate wrong");

   // Permission-group attempts pass exactly when the permission-group lock is clear.
   AST_PG_LOCK: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      permission_group_wr_req_i |-> (permission_group_wr_allow_o != ctrl_q[PG_LOCK_BIT]))
      else $error("permission group gate wrong");

   // The PHY clock stops only in sleep with the stop bit set.
   AST_USB_STOP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      usb_phy_clk_stopped_o == (ctrl_q[USB_STOP_BIT] && sleep_active_i))
      else $error("usb phy stop wrong");

   // The low byte is never locked, so a write there always lands.
   AST_LOW_BYTE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (wr_ctrl && pstrb_i[0]) |=> ctrl_q[7:0] == ($past(pwdata_i[7:0]) & SYSCFG_IMPL_MASK[7:0]))
      else $error("low byte write lost");

   // A lane without its strobe keeps its bits.
   AST_LANE3_KEEP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (wr_ctrl && !pstrb_i[3]) |=> ctrl_q[31:24] == $past(ctrl_q[31:24]))
      else $error("lane three moved without strobe");

   // A lane without its strobe keeps its bits.
   AST_LANE2_KEEP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (wr_ctrl && !pstrb_i[2]) |=> ctrl_q[23:16] == $past(ctrl_q[23:16]))
      else $error("lane two moved without strobe");

   // A lane without its strobe keeps its bits.
   AST_LANE1_KEEP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (wr_ctrl && !pstrb_i[1]) |=> ctrl_q[15:8] == $past(ctrl_q[15:8]))
      else $error("lane one moved without strobe");

   // A lane without its strobe keeps its bits.
   AST_LANE0_KEEP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (wr_ctrl && !pstrb_i[0]) |=> ctrl_q[7:0] == $past(ctrl_q[7:0]))
      else $error("lane zero moved without strobe");

   // A low clock enable freezes the control word, bus or no bus.
   AST_FREEZE_CTRL: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !clk_en_i |=> ctrl_q == $past(ctrl_q))
      else $error("control word moved while frozen");

   // A low clock enable freezes the dropped-write flag.
   AST_FREEZE_DROP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !clk_en_i |=> dropped_q == $past(dropped_q))
      else $error("dropped flag moved while frozen");

   // A low clock enable freezes the qualified unlock level.
   AST_FREEZE_UNLOCK: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !clk_en_i |=> unlock_q == $past(unlock_q))
      else $error("unlock moved while frozen");

   // A low clock enable freezes the read data.
   AST_FREEZE_RDATA: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !clk_en_i |=> prdata_o == $past(prdata_o))
      else $error("read data moved while frozen");

   // The unlock level moves only when the last two stages agree.
   AST_SYNC_AGREE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (unlock_q != $past(unlock_q)) |-> ($past(unlock_sync_q[2]) == $past(unlock_sync_q[1])))
      else $error("unlock taken before stages agree");

   // The unlock level takes the value of the last stage.
   AST_SYNC_VALUE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (unlock_q != $past(unlock_q)) |-> unlock_q == $past(unlock_sync_q[2]))
      else $error("unlock took a wrong value");

   // A full unlocked write lands on every implemented bit.
   AST_UNLOCKED_WORD: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (wr_ctrl && unlock_q && pstrb_i == 4'hf) |=> ctrl_q == ($past(pwdata_i) & SYSCFG_IMPL_MASK))
      else $error("unlocked write not applied");

   // A control read returns the implemented bits only.
   AST_READ_CTRL: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (rd_setup && clk_en_i && hit_ctrl) |=> prdata_o == ($past(ctrl_q) & SYSCFG_IMPL_MASK))
      else $error("control read data wrong");

   // A status read returns the flag and the unlock level.
   AST_READ_STAT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (rd_setup && clk_en_i && hit_stat) |=> prdata_o == {30'h0, $past(dropped_q), $past(unlock_q)})
      else $error("status read data wrong");

   // An unmapped read returns zero.
   AST_READ_HOLE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (rd_setup && clk_en_i && !hit_any) |=> prdata_o == 32'h0)
      else $error("unmapped read not zero");

   // Read data stands until the next read setup.
   AST_RDATA_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !(rd_setup && clk_en_i) |=> $stable(prdata_o))
      else $error("read data changed outside setup");

   // Mapped addresses never report an error.
   AST_SLVERR_MAP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (psel_i && penable_i && hit_any) |-> !pslverr_o)
      else $error("error on mapped address");

   // Unmapped addresses always report an error.
   AST_SLVERR_HOLE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (psel_i && penable_i && !hit_any) |-> pslverr_o)
      else $error("no error on unmapped address");

   // A write to an unmapped address leaves the word alone.
   AST_HOLE_WRITE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (access && pwrite_i && !hit_any) |=> ctrl_q == $past(ctrl_q))
      else $error("unmapped write changed the word");

   // A status write leaves the control word alone.
   AST_STAT_WRITE_KEEP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (access && pwrite_i && hit_stat) |=> ctrl_q == $past(ctrl_q))
      else $error("status write changed the word");

   // Writing one to the flag clears it.
   AST_DROP_CLEAR: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (access && pwrite_i && hit_stat && pwdata_i[STAT_DROPPED_BIT]) |=> !dropped_q)
      else $error("dropped flag not cleared");

   // The flag stays set until software clears it.
   AST_DROP_STICKY: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (dropped_q && !(access && pwrite_i && hit_stat)) |=> dropped_q)
      else $error("dropped flag lost");

   // The flag rises only on a refused change.
   AST_DROP_QUIET: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (!dropped_q && !locked_hit) |=> !dropped_q)
      else $error("dropped flag rose without cause");

   // Outside interrupt service the CPU never gets priority.
   AST_CPU_IDLE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !cpu_in_isr_i |-> !cpu_sram_high_priority_o)
      else $error("cpu priority without interrupt");

   // A clear pin-select lock lets every attempt through.
   AST_PIN_OPEN: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (pin_select_wr_req_i && !ctrl_q[PIN_LOCK_BIT]) |-> pin_select_wr_allow_o)
      else $error("pin select write refused while open");

   // A stopped PHY clock stays low.
   AST_USB_GATE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      usb_phy_clk_stopped_o |-> !usb_phy_clk_gated_o)
      else $error("phy clock runs while stopped");

   // The error-correction field leaves reset at its documented value.
   AST_RESET_FIELDS: assert property (@(posedge clk_i)
      $rose(reset_n_i) |-> memory_error_correction_control_o == SYSCFG_CTRL_RESET[ECC_LO_BIT+1:ECC_LO_BIT])
      else $error("error-correction field not at reset value");

   // While locked no protected bit moves, whatever the bus does.
   AST_LOCK_STEADY: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !unlock_q |=> ((ctrl_q & SYSCFG_LOCKED_MASK) == ($past(ctrl_q) & SYSCFG_LOCKED_MASK)))
      else $error("protected bits moved without unlock");

   // DMA priority moves only by a control write.
   AST_DMA_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !wr_ctrl |=> $stable(dma_sram_high_priority_o))
      else $error("dma priority moved without write");

   // Compare timebase moves only by a control write.
   AST_TIMEBASE_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !wr_ctrl |=> $stable(compare_alt_timebase_select_o))
      else $error("compare timebase moved without write");

endmodule : system_configuration_control

// *** design/syscfg_pkg.sv ***
package syscfg_pkg;

   // Register map and field layout of the configuration control word.
   localparam logic [11:0] SYSCFG_CTRL_OFFSET = 12'h000;
   localparam logic [11:0] SYSCFG_STAT_OFFSET = 12'h004;
   localparam logic [31:0] SYSCFG_CTRL_RESET  = 32'h0000_0039;
   localparam logic [31:0] SYSCFG_IMPL_MASK   = 32'h0303_39bd;
   localparam logic [31:0] SYSCFG_LOCKED_MASK = 32'h0303_3900;

   localparam int DMA_PRI_BIT     = 25;
   localparam int CPU_PRI_BIT     = 24;
   localparam int CAP_ALT_BIT     = 17;
   localparam int CMP_ALT_BIT     = 16;
   localparam int PIN_LOCK_BIT    = 13;
   localparam int PMD_LOCK_BIT    = 12;
   localparam int PG_LOCK_BIT     = 11;
   localparam int USB_STOP_BIT    = 8;
   localparam int ANA_PUMP_BIT    = 7;
   localparam int ECC_LO_BIT      = 4;
   localparam int JTAG_BIT        = 3;
   localparam int TRACE_BIT       = 2;
   localparam int TDO_BIT         = 0;

   // Status word fields.
   localparam int STAT_UNLOCK_BIT  = 0;
   localparam int STAT_DROPPED_BIT = 1;

endpackage : syscfg_pkg

// *** tb/system_configuration_control_test.sv ***
module system_configuration_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   import syscfg_pkg::*;
   logic        clk_i = 0, reset_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic [11:0] paddr_i = '0;
   logic [31:0] pwdata_i = '0, prdata_o, rd;
   logic [3:0]  pstrb_i = 4'hf;
   logic        unlk = 0, isr = 0, slp = 0, req = 1, err, en = 1, phy = 1;
   logic        pready_o, pslverr_o, dma, cpu, cap, cmp, pin_ok, pmd_ok, pg_ok, stopped;
   logic [1:0]  ecc;
   logic        jtag, trc, tdo, pump, gated;
   int          errors = 0, checks_done = 0;

   system_configuration_control dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(en), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .system_unlocked_i(unlk),
      .cpu_in_isr_i(isr), .sleep_active_i(slp), .usb_phy_clk_i(phy), .pin_select_wr_req_i(req),
      .module_disable_wr_req_i(req), .permission_group_wr_req_i(req), .dma_sram_high_priority_o(dma),
      .cpu_sram_high_priority_o(cpu), .capture_alt_timebase_select_o(cap), .compare_alt_timebase_select_o(cmp),
      .pin_select_wr_allow_o(pin_ok), .module_disable_wr_allow_o(pmd_ok), .permission_group_wr_allow_o(pg_ok),
      .usb_phy_clk_gated_o(gated), .usb_phy_clk_stopped_o(stopped), .memory_error_correction_control_o(ecc),
      .boundary_scan_port_enable_o(jtag), .trace_output_enable_o(trc), .test_data_out_enable_o(tdo),
      .analog_io_charge_pump_enable_o(pump));

   // Free-running 100 MHz clock.
   always #5 clk_i = ~clk_i;

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : check

   // One APB transfer; the request is held until pready is sampled high.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel_i <= 1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
      @(posedge clk_i);
   endtask : apb

   task automatic test_done;
      if (errors == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done

   task automatic reset_state;
      apb(0, SYSCFG_CTRL_OFFSET, 0);
      check("reset word", rd, 32'h0000_0039);
      check("reset fields", {ecc, jtag, trc, tdo, pump}, 6'h3a);
      check("allows open", {pin_ok, pmd_ok, pg_ok}, 3'h7);
      check("phy clock passes", gated, 1);
      apb(0, SYSCFG_STAT_OFFSET, 0);
      check("status after reset", rd, 32'h0);
   endtask : reset_state

   // Without unlock only the low byte may move; holes stay zero.
   task automatic locked_write;
      apb(1, SYSCFG_CTRL_OFFSET, 32'hffff_ffff);
      apb(0, SYSCFG_CTRL_OFFSET, 0);
      check("locked word", rd, 32'h0000_00bd);
      check("dma still low", dma, 0);
      check("low fields", {ecc, jtag, trc, tdo, pump}, 6'h3f);
      apb(0, SYSCFG_STAT_OFFSET, 0);
      check("dropped flag set", rd, 32'h2);
      apb(1, SYSCFG_STAT_OFFSET, 32'h2);
      apb(0, SYSCFG_STAT_OFFSET, 0);
      check("dropped flag cleared", rd, 32'h0);
   endtask : locked_write

   task automatic unlocked_write;
      unlk <= 1;
      repeat (8) @(posedge clk_i);
      apb(0, SYSCFG_STAT_OFFSET, 0);
      check("unlock seen", rd, 32'h1);
      apb(1, SYSCFG_CTRL_OFFSET, 32'hffff_ffff);
      apb(0, SYSCFG_CTRL_OFFSET, 0);
      check("unlocked word", rd, 32'h0303_39bd);
      check("dma high", dma, 1);
      check("timebase alt", {cap, cmp}, 2'h3);
      check("allows shut", {pin_ok, pmd_ok, pg_ok}, 3'h0);
      check("cpu idle", cpu, 0);
      check("phy runs", {stopped, gated}, 2'h1);
      isr <= 1;
      slp <= 1;
      @(posedge clk_i);
      #1;
      check("cpu in isr", cpu, 1);
      check("phy stops", {stopped, gated}, 2'h2);
   endtask : unlocked_write

   // With the clock enable low a write must not land.
   task automatic freeze;
      en <= 0;
      apb(1, SYSCFG_CTRL_OFFSET, 32'h0);
      en <= 1;
      apb(0, SYSCFG_CTRL_OFFSET, 0);
      check("frozen word", rd, 32'h0303_39bd);
   endtask : freeze

   task automatic clear_all;
      apb(1, SYSCFG_CTRL_OFFSET, 32'h0);
      apb(0, SYSCFG_CTRL_OFFSET, 0);
      check("cleared word", rd, 32'h0);
      check("dma low", dma, 0);
      check("timebase base", {cap, cmp}, 2'h0);
      check("allows back", {pin_ok, pmd_ok, pg_ok}, 3'h7);
      check("phy after clear", {cpu, stopped, gated}, 3'h1);
      check("fields cleared", {ecc, jtag, trc, tdo, pump}, 6'h0);
      apb(1, 12'h010, 32'hffff_ffff);
      apb(0, 12'h010, 0);
      check("unmapped error", err, 1);
      check("unmapped data", rd, 32'h0);
      apb(0, SYSCFG_CTRL_OFFSET, 0);
      check("unmapped write ignored", rd, 32'h0);
   endtask : clear_all

   // A hung bus would stall the sequence; stop well past its expected length.
   initial begin
      #100us;
      errors++;
      test_done();
   end

   initial begin
      repeat (8) @(posedge clk_i);
      reset_n_i <= 1;
      @(posedge clk_i);
      reset_state();
      locked_write();
      unlocked_write();
      freeze();
      clear_all();
      test_done();
   end
endmodule : system_configuration_control_test
